// *** supply_wake_failmode_supervisor_test.sv ***
/*
 Self-checking bench for the supervisor with a host pin model.
 Assumes the package deglitch count and two-edge output latency.
*/
`timescale 1ns/1ps
module supply_wake_failmode_supervisor_test
    import swfs_pkg::*;
;
    logic        core_clk = 0, rst_n = 0, batOk = 1, logicSupplyOk = 1, gndOk = 1;
    logic        wakeReq = 0, wakeByResetPin = 0, spiError = 0, spiWatchdogTimeout = 0;
    logic        spiReadValid = 0, extDriveSpiBit = 1, faultClear = 0;
    logic        cmdFail = 0, cmdRstN = 0, cmdFloat = 0;
    logic [3:0]  cmdDir = 4'h5, pwmChannels = 4'ha, directChannelInputs, power_channel_outputs;
    logic [7:0]  faultEvents = 8'h00, faultFlags, deviceStatus7;
    logic [15:0] spiReadData = 16'h5a3c, spiReadOut;
    logic        failForcePin, activeLowResetPinN, clkPinIn, clkPinOut, clkPinOe, clkPinSeen;
    logic        spiReadOutValid, external_switch_drive_output, failModeActive, awake;
    int          errTotal = 0, checks = 0;

    swfs_supervisor i_swfs_supervisor (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .batOk(batOk),
        .logicSupplyOk(logicSupplyOk),
        .gndOk(gndOk),
        .wakeReq(wakeReq),
        .wakeByResetPin(wakeByResetPin),
        .activeLowResetPinN(activeLowResetPinN),
        .failForcePin(failForcePin),
        .directChannelInputs(directChannelInputs),
        .clkPinIn(clkPinIn),
        .clkPinOut(clkPinOut),
        .clkPinOe(clkPinOe),
        .spiError(spiError),
        .spiWatchdogTimeout(spiWatchdogTimeout),
        .spiReadValid(spiReadValid),
        .spiReadData(spiReadData),
        .spiReadOut(spiReadOut),
        .spiReadOutValid(spiReadOutValid),
        .extDriveSpiBit(extDriveSpiBit),
        .pwmChannels(pwmChannels),
        .faultEvents(faultEvents),
        .faultClear(faultClear),
        .power_channel_outputs(power_channel_outputs),
        .external_switch_drive_output(external_switch_drive_output),
        .faultFlags(faultFlags),
        .deviceStatus7(deviceStatus7),
        .failModeActive(failModeActive),
        .awake(awake),
        .clkPinSeen(clkPinSeen)
    );
    swfs_host_model i_swfs_host_model (
        .cmdFail(cmdFail),
        .cmdDir(cmdDir),
        .cmdRstN(cmdRstN),
        .cmdFloat(cmdFloat),
        .failForcePin(failForcePin),
        .directChannelInputs(directChannelInputs),
        .activeLowResetPinN(activeLowResetPinN),
        .clkPinOut(clkPinOut),
        .clkPinOe(clkPinOe),
        .clkPinIn(clkPinIn)
    );

    always #20 core_clk = ~core_clk;

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finishTest();
        if (errTotal == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (2 * DGL_CYC + 2000) @(posedge core_clk);
        errTotal++;
        finishTest();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        wt(4);
        chk(awake, 1'b0);
        chk(clkPinOe, 1'b0);
        @(posedge core_clk);
        wakeReq <= 1'b1;
        wt(8);
        chk(awake, 1'b1);
        chk({clkPinOe, clkPinOut, clkPinSeen}, 3'b111);
        chk(power_channel_outputs, 4'ha);
        @(posedge core_clk);
        wakeByResetPin <= 1'b1;
        wt(3);
        chk(clkPinOe, 1'b0);
        @(posedge core_clk);
        wakeByResetPin <= 1'b0;
        cmdRstN <= 1'b1;
        wt(6);
        chk(clkPinOe, 1'b0);
        @(posedge core_clk);
        cmdRstN <= 1'b0;
        wt(6);
        chk(clkPinOe, 1'b1);
        for (int i = 0; i < FLT_W; i++) begin
            @(posedge core_clk);
            faultEvents <= 8'h01 << i;
            pwmChannels <= 4'(i);
            wt(3);
            chk(faultFlags, 8'hff >> (7 - i));
        end
        // Clear request during battery loss must not land
        @(posedge core_clk);
        faultEvents <= 8'h00;
        batOk <= 1'b0;
        faultClear <= 1'b1;
        wt(3);
        chk(power_channel_outputs, 4'h0);
        chk(external_switch_drive_output, 1'b1);
        chk(faultFlags, 8'hff);
        chk(clkPinOe, 1'b0);
        @(posedge core_clk);
        faultClear <= 1'b0;
        batOk <= 1'b1;
        gndOk <= 1'b0;
        wt(3);
        chk(power_channel_outputs, 4'h0);
        @(posedge core_clk);
        faultClear <= 1'b1;
        faultEvents <= 8'h04;
        @(posedge core_clk);
        faultClear <= 1'b0;
        faultEvents <= 8'h00;
        wt(2);
        chk(faultFlags, 8'h04);
        @(posedge core_clk);
        gndOk <= 1'b1;
        spiReadValid <= 1'b1;
        wt(1);
        chk(spiReadOutValid, 1'b1);
        chk(spiReadOut, 16'h5a3c);
        @(posedge core_clk);
        logicSupplyOk <= 1'b0;
        wt(3);
        chk(spiReadOutValid, 1'b0);
        chk(failModeActive, 1'b1);
        @(posedge core_clk);
        logicSupplyOk <= 1'b1;
        wt(3);
        chk({failModeActive, deviceStatus7[ST_SPIF]}, 2'b00);
        @(posedge core_clk);
        spiError <= 1'b1;
        wt(3);
        chk({failModeActive, deviceStatus7[ST_SPIF]}, 2'b11);
        @(posedge core_clk);
        spiError <= 1'b0;
        wt(3);
        chk({failModeActive, deviceStatus7[ST_SPIF]}, 2'b00);
        @(posedge core_clk);
        spiWatchdogTimeout <= 1'b1;
        wt(3);
        chk(failModeActive, 1'b1);
        @(posedge core_clk);
        spiWatchdogTimeout <= 1'b0;
        wt(3);
        chk({failModeActive, deviceStatus7[ST_SPIF]}, 2'b00);
        @(posedge core_clk);
        cmdFail <= 1'b1;
        pwmChannels <= 4'ha;
        wt(DGL_CYC - 10);
        chk(failModeActive, 1'b0);
        chk(power_channel_outputs, 4'ha);
        wt(20);
        chk(deviceStatus7[ST_FAILFORCE], 1'b1);
        chk(failModeActive, 1'b1);
        chk(power_channel_outputs, 4'h5);
        // SPI error keeps fail mode while the pins float
        @(posedge core_clk);
        cmdFloat <= 1'b1;
        spiError <= 1'b1;
        wt(DGL_CYC + 10);
        chk(deviceStatus7[ST_FAILFORCE], 1'b0);
        chk(power_channel_outputs, 4'h0);
        @(posedge core_clk);
        batOk <= 1'b0;
        logicSupplyOk <= 1'b0;
        wt(3);
        chk({power_channel_outputs, external_switch_drive_output}, 5'h00);
        chk({faultFlags, deviceStatus7}, 16'h0000);
        finishTest();
    end
endmodule

bind swfs_supervisor swfs_supervisor_asserts i_swfs_supervisor_asserts (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .batOk(batOk),
    .logicSupplyOk(logicSupplyOk),
    .gndOk(gndOk),
    .wakeReq(wakeReq),
    .wakeByResetPin(wakeByResetPin),
    .activeLowResetPinN(activeLowResetPinN),
    .failForcePin(failForcePin),
    .spiError(spiError),
    .pwmChannels(pwmChannels),
    .clkPinOe(clkPinOe),
    .clkPinOut(clkPinOut),
    .spiReadOutValid(spiReadOutValid),
    .power_channel_outputs(power_channel_outputs),
    .external_switch_drive_output(external_switch_drive_output),
    .faultFlags(faultFlags),
    .deviceStatus7(deviceStatus7),
    .failModeActive(failModeActive),
    .awake(awake)
);

// *** swfs_deglitch.sv ***
/*
 Three-flop synchroniser and symmetric deglitch counter for one pin.
 Assumes a synchronous active-low reset copy from the top module.
*/
`timescale 1ns/1ps
module swfs_deglitch
    import swfs_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstN,
    // Pin
    swfs_dgl_if.filter      dgl
);
    logic [2:0]       syncR;
    logic [2:0]       syncNxt;
    logic [DGL_W-1:0] cntR;
    logic [DGL_W-1:0] cntNxt;
    logic             filtR;
    logic             filtNxt;

    always_comb begin
        syncNxt = {syncR[1:0], dgl.raw};
        cntNxt  = '0;
        filtNxt = filtR;
        // Level changes only once stages two and three agree
        if (syncR[2] == syncR[1] && syncR[2] != filtR) begin
            cntNxt = cntR + 1'b1;
            if (cntR + 1'b1 >= DGL_MAX) begin
                filtNxt = syncR[2];
                cntNxt  = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            syncR <= 3'h0;
            cntR  <= '0;
            filtR <= 1'b0;
        end else begin
            syncR <= syncNxt;
            cntR  <= cntNxt;
            filtR <= filtNxt;
        end
    end

    assign dgl.filt = filtR;
endmodule

// *** swfs_host_model.sv ***
/*
 Host controller model for the supervisor pins: fail-force, direct inputs,
 reset pin and the shared clock pin. Assumes the bench sets the commands.
*/
`timescale 1ns/1ps
module swfs_host_model (
    // Commands from the bench
    input  wire logic       cmdFail,
    input  wire logic [3:0] cmdDir,
    input  wire logic       cmdRstN,
    input  wire logic       cmdFloat,
    // Pins
    output logic            failForcePin,
    output logic [3:0]      directChannelInputs,
    output logic            activeLowResetPinN,
    input  wire logic       clkPinOut,
    input  wire logic       clkPinOe,
    output logic            clkPinIn
);
    // Released pins float; the device pull-downs decide
    assign failForcePin        = cmdFloat ? 1'bz : cmdFail;
    assign directChannelInputs = cmdFloat ? 4'hz : cmdDir;
    assign activeLowResetPinN  = cmdRstN;
    // Host clock idles low outside frames, device wins when driving
    assign clkPinIn = clkPinOe ? clkPinOut : 1'b0;
endmodule

// *** swfs_if.sv ***
/*
 Interface carrying one raw pin into a deglitch filter and its filtered
 level back. Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface swfs_dgl_if;
    logic raw;
    logic filt;
    modport filter (input raw, output filt);
    modport user   (output raw, input filt);
endinterface

// *** swfs_pkg.sv ***
/*
 Package for the supply, wake and fail-mode supervisor: timing counts,
 channel count and status bit positions. Assumes a 25 MHz core clock.
*/
package swfs_pkg;
    localparam int          CLK_HZ        = 25000000;
    localparam int          NUM_CH        = 4;
    // Deglitch interval in microseconds, and the derived count (whole MHz, rounded down, at least one cycle)
    localparam int          DGL_US        = 200;
    localparam int          DGL_CYC       = (DGL_US * (CLK_HZ / 1000000) + 0) < 1 ? 1 :
                                            DGL_US * (CLK_HZ / 1000000);
    localparam int          DGL_W         = 13;
    localparam logic [12:0] DGL_MAX       = 13'(DGL_CYC);
    // Device status word bit positions
    localparam int          ST_FAILFORCE  = 0;
    localparam int          ST_SPIF       = 1;
    localparam int          ST_FAILMODE   = 2;
    localparam int          ST_W          = 8;
    localparam logic [7:0]  ST_RESET      = 8'h00;
    // Fault flag bit positions
    localparam int          FLT_OPENLOAD  = 0;
    localparam int          FLT_SHORTBAT  = 1;
    localparam int          FLT_SEVSHORT  = 2;
    localparam int          FLT_OVERCUR   = 3;
    localparam int          FLT_OVERTEMP  = 4;
    localparam int          FLT_CLKFAIL   = 5;
    localparam int          FLT_UNDERV    = 6;
    localparam int          FLT_OVERV     = 7;
    localparam int          FLT_W         = 8;
    localparam logic [7:0]  FLT_RESET     = 8'h00;

    typedef enum {SWFS_OFF, SWFS_SLEEP, SWFS_NORMAL, SWFS_FAIL} swfs_mode_t;
endpackage

// *** swfs_supervisor.sv ***
/*
 Supply, wake and fail-mode supervisor for a quad high-side switch.
 Supply-detect levels, ground-loss, wake, watchdog and fault events come
 from analog and SPI blocks outside as levels in this clock domain;
 fail-force and direct-input pins from the host pass the deglitch filter.
//Summary of operation
//- Logic runs only while wake is 1; otherwise sleep.
//- Reset pin low and woken by other source: drive clock pin high.
//- Sleep or woken by reset pin: clock pin left as input.
//- Both supplies lost: outputs off, registers and faults cleared.
//- Battery lost, logic supply valid: registers and faults kept.
//- Battery lost: channels off, external drive follows its SPI bit.
//- Battery lost: no wake report on the clock pin.
//- Logic supply lost with battery valid: enter watchdog timeout handling.
//- No valid SPI read data without the logic supply.
//- Ground lost: channels one to four off.
//- Normal mode: channels driven by the PWM module from SPI settings.
//- Report eight fault classes through SPI.
//- Direct inputs honoured only in fail mode; no logic supply needed.
//- Fail-force input at 1 enters fail mode.
//- Fail mode: each channel follows its direct input.
//- Fail-force level readable in device status register seven.
//- Fail-force must hold 1 beyond about 200 us first.
//- SPI communication error or watchdog timeout enters fail mode.
*/
`timescale 1ns/1ps
module swfs_supervisor
    import swfs_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Supply and ground monitors
    input  wire logic              batOk,
    input  wire logic              logicSupplyOk,
    input  wire logic              gndOk,
    // Wake sources
    input  wire logic              wakeReq,
    input  wire logic              wakeByResetPin,
    // Host pins
    input  wire logic              activeLowResetPinN,
    input  wire logic              failForcePin,
    input  wire logic [NUM_CH-1:0] directChannelInputs,
    input  wire logic              clkPinIn,
    output logic                   clkPinOut,
    output logic                   clkPinOe,
    // SPI side
    input  wire logic              spiError,
    input  wire logic              spiWatchdogTimeout,
    input  wire logic              spiReadValid,
    input  wire logic [15:0]       spiReadData,
    output logic [15:0]            spiReadOut,
    output logic                   spiReadOutValid,
    input  wire logic              extDriveSpiBit,
    // PWM and fault sources
    input  wire logic [NUM_CH-1:0] pwmChannels,
    input  wire logic [FLT_W-1:0]  faultEvents,
    input  wire logic              faultClear,
    // Outputs
    output logic [NUM_CH-1:0]      power_channel_outputs,
    output logic                   external_switch_drive_output,
    output logic [FLT_W-1:0]       faultFlags,
    output logic [ST_W-1:0]        deviceStatus7,
    output logic                   failModeActive,
    output logic                   awake,
    output logic                   clkPinSeen
);
    // Reset release through two flops
    logic [1:0] rstSyncR;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSyncR <= 2'b00;
        end else begin
            rstSyncR <= {rstSyncR[0], 1'b1};
        end
    end
    logic rstN;
    assign rstN = rstSyncR[1];

    // Full-length filter delays fail entry, but short spikes cannot force it
    // deglitched fail-force
    // pull-down, so undriven pins look low
    swfs_dgl_if failIf ();
    assign failIf.raw = failForcePin === 1'b1;
    swfs_deglitch uFailDgl (
        .clk  (core_clk),
        .rstN (rstN),
        .dgl  (failIf.filter)
    );

    logic [NUM_CH-1:0] directFilt;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : gDirect
            swfs_dgl_if dirIf ();
            assign dirIf.raw = directChannelInputs[gi] === 1'b1;
            swfs_deglitch uDirDgl (
                .clk  (core_clk),
                .rstN (rstN),
                .dgl  (dirIf.filter)
            );
            assign directFilt[gi] = dirIf.filt;
        end
    endgenerate

    // Three-flop sampler for the clock pin read-back and the reset pin
    logic [2:0] clkPinSyncR;
    logic [2:0] rstPinSyncR;
    logic       clkSeenR;
    logic       rstPinR;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            clkPinSyncR <= 3'h0;
            // Reset pin idles high; starting high avoids a false wake report
            rstPinSyncR <= 3'h7;
            clkSeenR    <= 1'b0;
            rstPinR     <= 1'b1;
        end else begin
            clkPinSyncR <= {clkPinSyncR[1:0], clkPinIn};
            rstPinSyncR <= {rstPinSyncR[1:0], activeLowResetPinN};
            if (clkPinSyncR[2] == clkPinSyncR[1]) begin
                clkSeenR <= clkPinSyncR[2];
            end
            if (rstPinSyncR[2] == rstPinSyncR[1]) begin
                rstPinR <= rstPinSyncR[2];
            end
        end
    end

    // Mode, latched SPI failure and faults
    swfs_mode_t        modeR;
    swfs_mode_t        modeNxt;
    logic              spiFailR;
    logic              spiFailNxt;
    logic [FLT_W-1:0]  faultR;
    logic [FLT_W-1:0]  faultNxt;
    logic              powerOff;
    logic              batLost;
    logic              commFail;

    assign powerOff = !batOk && !logicSupplyOk;
    assign batLost  = !batOk && logicSupplyOk;
    // missing logic supply is handled as watchdog timeout
    assign commFail = spiError || spiWatchdogTimeout || (batOk && !logicSupplyOk);

    always_comb begin
        modeNxt    = modeR;
        spiFailNxt = spiFailR;
        faultNxt   = faultR;
        if (powerOff) begin
            modeNxt    = SWFS_OFF;
            spiFailNxt = 1'b0;
            faultNxt   = FLT_RESET;
        end else if (batLost) begin
            // retain state while the battery is away
            modeNxt    = modeR;
        end else begin
            // sticky fault classes; a new event beats a clear
            faultNxt = (faultClear ? FLT_RESET : faultR) | faultEvents;
            if (commFail) begin
                spiFailNxt = 1'b1;
            end
            case (modeR)
                SWFS_OFF, SWFS_SLEEP: begin
                    if (wakeReq) begin
                        modeNxt = (failIf.filt || commFail) ? SWFS_FAIL : SWFS_NORMAL;
                    end else begin
                        modeNxt = SWFS_SLEEP;
                    end
                end
                SWFS_NORMAL: begin
                    if (!wakeReq) begin
                        modeNxt = SWFS_SLEEP;
                    end else if (failIf.filt || commFail) begin
                        modeNxt = SWFS_FAIL;
                    end
                end
                SWFS_FAIL: begin
                    if (!wakeReq) begin
                        modeNxt = SWFS_SLEEP;
                    end else if (!failIf.filt && !commFail) begin
                        // Failure flag drops on fail-to-normal
                        modeNxt    = SWFS_NORMAL;
                        spiFailNxt = 1'b0;
                    end
                end
                default: modeNxt = SWFS_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            modeR    <= SWFS_OFF;
            spiFailR <= 1'b0;
            faultR   <= FLT_RESET;
        end else begin
            modeR    <= modeNxt;
            spiFailR <= spiFailNxt;
            faultR   <= faultNxt;
        end
    end

    // Output stage, all registered: one extra cycle,
    // but the pins never glitch while the mode decodes
    logic [NUM_CH-1:0] chNxt;
    logic [NUM_CH-1:0] chR;
    logic              extNxt;
    logic              extR;
    logic              clkOeNxt;
    logic              clkOeR;
    logic [15:0]       rdNxt;
    logic [15:0]       rdR;
    logic              rdVNxt;
    logic              rdVR;

    always_comb begin
        chNxt    = '0;
        extNxt   = 1'b0;
        clkOeNxt = 1'b0;
        rdNxt    = 16'h0000;
        rdVNxt   = 1'b0;
        case (modeR)
            // PWM drives channels in normal mode
            SWFS_NORMAL: begin
                chNxt  = pwmChannels;
                extNxt = extDriveSpiBit;
            end
            SWFS_FAIL: chNxt = directFilt;
            default: chNxt = '0;
        endcase
        // channels off, external drive keeps SPI bit
        if (batLost) begin
            chNxt  = '0;
            extNxt = extDriveSpiBit;
        end
        if (!gndOk || powerOff) begin
            chNxt = '0;
        end
        if (powerOff) begin
            extNxt = 1'b0;
        end
        // report wake while reset pin is low
        // stays input in sleep or reset-pin wake
        if ((modeR == SWFS_NORMAL || modeR == SWFS_FAIL) && !rstPinR
            && !wakeByResetPin && batOk) begin
            clkOeNxt = 1'b1;
        end
        // read data only with logic supply present
        if (logicSupplyOk && spiReadValid) begin
            rdNxt  = spiReadData;
            rdVNxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            chR    <= '0;
            extR   <= 1'b0;
            clkOeR <= 1'b0;
            rdR    <= 16'h0000;
            rdVR   <= 1'b0;
        end else begin
            chR    <= chNxt;
            extR   <= extNxt;
            clkOeR <= clkOeNxt;
            rdR    <= rdNxt;
            rdVR   <= rdVNxt;
        end
    end

    assign power_channel_outputs        = chR;
    assign external_switch_drive_output = extR;
    assign clkPinOut                    = clkOeR;
    assign clkPinOe                     = clkOeR;
    assign spiReadOut                   = rdR;
    assign spiReadOutValid              = rdVR;
    assign faultFlags                   = faultR;
    assign failModeActive               = modeR == SWFS_FAIL;
    assign awake                        = modeR == SWFS_NORMAL || modeR == SWFS_FAIL;
    assign clkPinSeen                   = clkSeenR;

    always_comb begin
        deviceStatus7               = ST_RESET;
        deviceStatus7[ST_FAILFORCE] = failIf.filt;
        deviceStatus7[ST_SPIF]      = spiFailR;
        deviceStatus7[ST_FAILMODE]  = modeR == SWFS_FAIL;
    end
endmodule

// *** swfs_supervisor_asserts.sv ***
/*
 Checker on the supervisor top ports.
 Assumes mode moves one edge and outputs two edges after their cause.
*/
`timescale 1ns/1ps
module swfs_supervisor_asserts
    import swfs_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst_n,
    // Causes
    input wire logic              batOk,
    input wire logic              logicSupplyOk,
    input wire logic              gndOk,
    input wire logic              wakeReq,
    input wire logic              wakeByResetPin,
    input wire logic              activeLowResetPinN,
    input wire logic              failForcePin,
    input wire logic              spiError,
    input wire logic [NUM_CH-1:0] pwmChannels,
    // Effects
    input wire logic              clkPinOe,
    input wire logic              clkPinOut,
    input wire logic              spiReadOutValid,
    input wire logic [NUM_CH-1:0] power_channel_outputs,
    input wire logic              external_switch_drive_output,
    input wire logic [FLT_W-1:0]  faultFlags,
    input wire logic [ST_W-1:0]   deviceStatus7,
    input wire logic              failModeActive,
    input wire logic              awake
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Run length of a high fail-force pin, saturating; a floating pin restarts it
    logic [DGL_W-1:0] forceRunR;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            forceRunR <= '0;
        end else if (failForcePin) begin
            if (forceRunR != '1) begin
                forceRunR <= forceRunR + 1'b1;
            end
        end else begin
            forceRunR <= '0;
        end
    end

    a_poweroff_clear: assert property (
        !batOk && !logicSupplyOk |=> power_channel_outputs == 0 && faultFlags == 0
        && external_switch_drive_output == 0) else $error("power-off did not clear");
    a_batloss_chan_off: assert property (
        !batOk |=> power_channel_outputs == 0) else $error("channels on without battery");
    a_batloss_hold: assert property (
        (!batOk && logicSupplyOk)[*2] |-> $stable(faultFlags)) else $error("faults moved");
    a_gnd_chan_off: assert property (
        !gndOk |=> power_channel_outputs == 0) else $error("channels on without ground");
    a_wake_report: assert property (
        (awake && wakeReq && batOk && logicSupplyOk && gndOk && !wakeByResetPin
        && !activeLowResetPinN)[*6] |-> clkPinOe && clkPinOut) else $error("no wake report");
    a_clk_released: assert property (
        (!wakeReq || wakeByResetPin || !batOk)[*2] |=> !clkPinOe) else $error("clock pin driven");
    a_read_gated: assert property (
        !logicSupplyOk |=> !spiReadOutValid) else $error("read data without logic supply");
    a_vcc_loss_fail: assert property (
        (awake && batOk && gndOk && wakeReq && !logicSupplyOk)[*2] |-> failModeActive)
        else $error("no fail mode on logic supply loss");
    a_spi_err_fail: assert property (
        (awake && batOk && gndOk && wakeReq && spiError)[*2] |-> failModeActive
        && deviceStatus7[ST_SPIF]) else $error("no fail mode on SPI error");
    a_normal_pwm: assert property (
        (awake && !failModeActive && batOk && gndOk && logicSupplyOk && wakeReq)[*2]
        |=> power_channel_outputs == $past(pwmChannels)) else $error("channels not from PWM");
    a_force_status: assert property (
        $rose(deviceStatus7[ST_FAILFORCE]) |-> forceRunR >= DGL_MAX)
        else $error("status bit without fail-force");
    a_force_mode: assert property (
        (deviceStatus7[ST_FAILFORCE] && awake && batOk && gndOk && wakeReq)[*2]
        |-> failModeActive) else $error("fail-force ignored");

    c_fail_entry: cover property ($rose(failModeActive));
    c_wake_report: cover property ($rose(clkPinOe));
    c_power_off: cover property (!batOk && !logicSupplyOk);
endmodule
